/* File: design/link_partner_ability_capture.sv */
// Captures the link partner's base and next page words for management reads
// Functional notes
// - A base page accepted from the partner is loaded into the ability register at 0x05.
// - After negotiation completes with next pages in use, a received next page replaces it.
// - Bit 15 shows the partner's next page request in both views.
// - Bit 14 shows whether the partner acknowledged our ability word.
// - Bit 14 is loaded with each accepted page and otherwise set or cleared by the negotiation logic's ack updates.
// - Bit 13 of the base view shows the partner's remote fault.
// - Bit 12 of the base view is reserved and always reads zero.
// - Bits 11 and 10 show the partner's asymmetric and symmetric pause abilities.
// - Bits 9 to 5 show the partner's T4, TX full, TX, 10 full and 10 half abilities.
// - Bits 4 to 0 hold the partner's selector and reset to zero.
// - In the next view bits 13, 12, 11 are message page, second ack, toggle; 10 to 0 the code.
`timescale 1ns/100ps
module link_partner_ability_capture (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic base_page_valid,
  input wire logic next_page_valid,
  input wire partner_ability_pkg::code_word_t rx_code_word,
  input wire logic an_complete,
  input wire logic next_page_enable,
  input wire logic ack_update,
  input wire logic ack_value,
  input wire logic mgmt_rd_en,
  input wire logic mgmt_wr_en,
  input wire logic [4:0] mgmt_addr,
  input wire partner_ability_pkg::code_word_t mgmt_wr_data,
  output partner_ability_pkg::code_word_t mgmt_rd_data,
  output logic mgmt_rd_valid,
  output logic next_page_view
);
  import partner_ability_pkg::*;

  page_view_t view_q;
  page_view_t view_d;
  code_word_t base_word_q;
  code_word_t next_word_q;
  code_word_t base_in;
  code_word_t next_in;
  code_word_t partner_ability_reg;
  code_word_t rd_data_q;
  code_word_t rd_data_d;
  logic rd_valid_q;
  logic rd_valid_d;
  logic next_accept;
  logic base_load;
  logic next_load;
  logic ack_only;

  // Decides whether a management access hits this register
  function automatic logic addr_hit(input logic [4:0] addr);
    addr_hit = (addr == PARTNER_ABILITY_ADDR);
  endfunction : addr_hit

  // Page acceptance and acknowledge updates
  always_comb begin
    next_accept = next_page_valid && an_complete && next_page_enable;
    ack_only = ack_update && !base_page_valid && !next_accept;
    base_in = base_word_q;
    next_in = next_word_q;
    if (base_page_valid) begin
      base_in = rx_code_word;
      base_in[RESERVED_BIT] = 1'b0;
    end else if (ack_only) begin
      base_in[ACK_BIT] = ack_value;
    end
    if (next_accept) begin
      next_in = rx_code_word;
    end else if (ack_only) begin
      next_in[ACK_BIT] = ack_value;
    end
    base_load = base_page_valid || (ack_only && view_q == VIEW_BASE);
    next_load = next_accept || (ack_only && view_q == VIEW_NEXT);
  end

  // Base page holding register
  page_word_store u_base_store (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .load(base_load),
    .load_word(base_in),
    .word_q(base_word_q)
  );

  // Next page holding register
  page_word_store u_next_store (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .load(next_load),
    .load_word(next_in),
    .word_q(next_word_q)
  );

  // View selection: a new base page returns to the base view
  always_comb begin
    view_d = view_q;
    unique case (view_q)
      VIEW_BASE: begin
        if (next_accept && !base_page_valid) begin
          view_d = VIEW_NEXT;
        end
      end
      VIEW_NEXT: begin
        if (base_page_valid) begin
          view_d = VIEW_BASE;
        end
      end
      default: begin
        view_d = VIEW_BASE;
      end
    endcase
  end

  // Word shown at the register address
  always_comb begin
    if (view_q == VIEW_NEXT) begin
      partner_ability_reg = next_word_q;
    end else begin
      partner_ability_reg = base_word_q;
    end
  end

  // Management read answer; writes to this read-only word are dropped
  always_comb begin
    rd_valid_d = mgmt_rd_en;
    rd_data_d = READ_IDLE;
    if (mgmt_rd_en && addr_hit(mgmt_addr)) begin
      rd_data_d = partner_ability_reg;
    end
  end

  // Register view state and read answer
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      view_q <= VIEW_BASE;
      rd_data_q <= READ_IDLE;
      rd_valid_q <= 1'b0;
    end else begin
      view_q <= view_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
    end
  end

  assign mgmt_rd_data = rd_data_q;
  assign mgmt_rd_valid = rd_valid_q;
  assign next_page_view = (view_q == VIEW_NEXT);

  // Base view never shows the reserved bit set
  property p_reserved_zero;
    @(posedge ref_clk) disable iff (!arst_n)
      (view_q == VIEW_BASE) |-> (partner_ability_reg[RESERVED_BIT] == 1'b0);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bit set in base view");

  // Accepted base page appears whole on the next cycle
  property p_base_load;
    @(posedge ref_clk) disable iff (!arst_n)
      base_page_valid |=> (view_q == VIEW_BASE) && (partner_ability_reg == $past(base_in));
  endproperty
  a_base_load: assert property (p_base_load)
    else $error("base page not captured");

  // Accepted next page replaces the register contents
  property p_next_load;
    @(posedge ref_clk) disable iff (!arst_n)
      (next_accept && !base_page_valid) |=>
        next_page_view && (partner_ability_reg == $past(rx_code_word));
  endproperty
  a_next_load: assert property (p_next_load)
    else $error("next page not captured");

  // Next page request bit follows the received word
  property p_np_bit;
    @(posedge ref_clk) disable iff (!arst_n)
      (base_page_valid || next_accept) |=>
        partner_ability_reg[NEXT_PAGE_BIT] == $past(rx_code_word[NEXT_PAGE_BIT]);
  endproperty
  a_np_bit: assert property (p_np_bit)
    else $error("next page request bit wrong");

  // Acknowledge follows the negotiation logic's update
  property p_ack_update;
    @(posedge ref_clk) disable iff (!arst_n)
      ack_only |=> partner_ability_reg[ACK_BIT] == $past(ack_value);
  endproperty
  a_ack_update: assert property (p_ack_update)
    else $error("acknowledge bit not updated");

  // Without a page or ack event the word stays put, whatever software writes
  property p_hold;
    @(posedge ref_clk) disable iff (!arst_n)
      (!base_page_valid && !next_accept && !ack_update) |=> $stable(partner_ability_reg);
  endproperty
  a_hold: assert property (p_hold)
    else $error("register changed without a page event");

  // Fault, pause and technology fields follow the base page
  property p_base_fields;
    @(posedge ref_clk) disable iff (!arst_n)
      base_page_valid |=>
        (partner_ability_reg[FAULT_BIT] == $past(rx_code_word[FAULT_BIT]))
        && (partner_ability_reg[ASYM_PAUSE_BIT:SYM_PAUSE_BIT]
            == $past(rx_code_word[ASYM_PAUSE_BIT:SYM_PAUSE_BIT]))
        && (partner_ability_reg[TECH_HI:TECH_LO] == $past(rx_code_word[TECH_HI:TECH_LO]));
  endproperty
  a_base_fields: assert property (p_base_fields)
    else $error("base page fields wrong");

  // Selector follows the base page
  property p_selector;
    @(posedge ref_clk) disable iff (!arst_n)
      base_page_valid |=>
        partner_ability_reg[SELECTOR_HI:SELECTOR_LO]
          == $past(rx_code_word[SELECTOR_HI:SELECTOR_LO]);
  endproperty
  a_selector: assert property (p_selector)
    else $error("selector field wrong");

  // Next view flag and code fields keep received values
  property p_next_fields;
    @(posedge ref_clk) disable iff (!arst_n)
      (next_accept && !base_page_valid) |=>
        (partner_ability_reg[MSG_PAGE_BIT:TOGGLE_BIT]
          == $past(rx_code_word[MSG_PAGE_BIT:TOGGLE_BIT]))
        && (partner_ability_reg[CODE_HI:CODE_LO] == $past(rx_code_word[CODE_HI:CODE_LO]));
  endproperty
  a_next_fields: assert property (p_next_fields)
    else $error("next page fields wrong");

  // A read returns the word shown at the request edge, a cycle later
  property p_read;
    @(posedge ref_clk) disable iff (!arst_n)
      (mgmt_rd_en && addr_hit(mgmt_addr)) |=>
        mgmt_rd_valid && (mgmt_rd_data == $past(partner_ability_reg));
  endproperty
  a_read: assert property (p_read)
    else $error("read answer wrong");

  // A management write of differing data, with no page or ack event, changes nothing
  property p_write_ignored;
    @(posedge ref_clk) disable iff (!arst_n)
      (mgmt_wr_en && addr_hit(mgmt_addr) && (mgmt_wr_data != partner_ability_reg)
        && !base_page_valid && !next_accept && !ack_update) |=> $stable(partner_ability_reg);
  endproperty
  a_write_ignored: assert property (p_write_ignored)
    else $error("management write changed the register");

endmodule : link_partner_ability_capture

/* File: design/partner_ability_pkg.sv */
// Constants and types shared by the partner ability capture block
package partner_ability_pkg;

  // Management address of the partner ability register
  localparam logic [4:0] PARTNER_ABILITY_ADDR = 5'h05;

  // Base page field positions
  localparam int NEXT_PAGE_BIT = 15;
  localparam int ACK_BIT = 14;
  localparam int FAULT_BIT = 13;
  localparam int RESERVED_BIT = 12;
  localparam int ASYM_PAUSE_BIT = 11;
  localparam int SYM_PAUSE_BIT = 10;
  localparam int TECH_HI = 9;
  localparam int TECH_LO = 5;
  localparam int SELECTOR_HI = 4;
  localparam int SELECTOR_LO = 0;

  // Next page field positions
  localparam int MSG_PAGE_BIT = 13;
  localparam int SECOND_ACKNOWLEDGE_BIT = 12;
  localparam int TOGGLE_BIT = 11;
  localparam int CODE_HI = 10;
  localparam int CODE_LO = 0;

  // Values after reset
  localparam logic [15:0] WORD_RESET = 16'h0000;
  localparam logic [4:0] SELECTOR_RESET = 5'h00;
  localparam logic [15:0] READ_IDLE = 16'h0000;

  typedef logic [15:0] code_word_t;

  // Which page the register address shows
  typedef enum logic [1:0] {
    VIEW_BASE = 2'b01,
    VIEW_NEXT = 2'b10
  } page_view_t;

endpackage : partner_ability_pkg

/* File: design/page_word_store.sv */
// Sixteen-bit holding register for one received page
`timescale 1ns/100ps
module page_word_store (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic load,
  input wire partner_ability_pkg::code_word_t load_word,
  output partner_ability_pkg::code_word_t word_q
);
  import partner_ability_pkg::*;

  code_word_t word_d;

  // Whole word replaced at once so a read never sees two pages mixed
  always_comb begin
    word_d = word_q;
    if (load) begin
      word_d = load_word;
    end
  end

  // Register the stored word
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      word_q <= WORD_RESET;
    end else begin
      word_q <= word_d;
    end
  end

endmodule : page_word_store

/* File: tb/cable_partner_model.sv */
// Far-end transceiver model that hands accepted code words to the capture block
`timescale 1ns/100ps
module cable_partner_model (
  input wire logic ref_clk,
  output logic base_page_valid,
  output logic next_page_valid,
  output partner_ability_pkg::code_word_t rx_code_word
);
  import partner_ability_pkg::*;

  // Quiet line at time zero
  initial begin
    base_page_valid = 1'b0;
    next_page_valid = 1'b0;
    rx_code_word = 16'h0000;
  end

  // One-cycle page pulse; the word is inverted afterwards so stale data is never trusted
  task send(input logic nxt, input code_word_t w);
    @(posedge ref_clk);
    base_page_valid <= !nxt;
    next_page_valid <= nxt;
    rx_code_word <= w;
    @(posedge ref_clk);
    base_page_valid <= 1'b0;
    next_page_valid <= 1'b0;
    rx_code_word <= ~w;
  endtask : send
endmodule : cable_partner_model

/* File: tb/link_partner_ability_capture_tb_top.sv */
// Self-checking bench for the partner ability capture block
`timescale 1ns/100ps
module link_partner_ability_capture_tb_top;
  import partner_ability_pkg::*;
  logic ref_clk, arst_n, base_page_valid, next_page_valid, an_complete, next_page_enable;
  logic ack_update, ack_value, mgmt_rd_en, mgmt_wr_en, mgmt_rd_valid, next_page_view;
  logic [4:0] mgmt_addr;
  code_word_t rx_code_word, mgmt_wr_data, mgmt_rd_data, shown;
  int fails = 0;
  int total_checks = 0;

  link_partner_ability_capture dut (.ref_clk, .arst_n, .base_page_valid, .next_page_valid,
    .rx_code_word, .an_complete, .next_page_enable, .ack_update, .ack_value, .mgmt_rd_en,
    .mgmt_wr_en, .mgmt_addr, .mgmt_wr_data, .mgmt_rd_data, .mgmt_rd_valid, .next_page_view);
  cable_partner_model p (.ref_clk, .base_page_valid, .next_page_valid, .rx_code_word);

  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task chk(input string what, input code_word_t exp, input code_word_t got);
    total_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, got);
      fails++;
    end
  endtask : chk

  // Read request, answer sampled one cycle after it is taken; valid and data then drop
  task rd(input logic [4:0] a, input code_word_t exp);
    @(posedge ref_clk);
    mgmt_rd_en <= 1'b1;
    mgmt_addr <= a;
    @(posedge ref_clk);
    mgmt_rd_en <= 1'b0;
    #1;
    chk("read valid", 16'h0001, {15'h0000, mgmt_rd_valid});
    chk("read data", exp, mgmt_rd_data);
    @(posedge ref_clk);
    #1;
    chk("read valid end", 16'h0000, {15'h0000, mgmt_rd_valid});
    chk("read data end", 16'h0000, mgmt_rd_data);
  endtask : rd

  task ack(input logic v);
    @(posedge ref_clk);
    ack_update <= 1'b1;
    ack_value <= v;
    @(posedge ref_clk);
    ack_update <= 1'b0;
  endtask : ack

  task t_reset;
    rd(5'h05, 16'h0000);
    chk("view", 16'h0000, {15'h0000, next_page_view});
  endtask : t_reset

  // Base pages carry every field; the reserved bit must come back clear
  task t_base;
    code_word_t w[4] = '{16'hFFFF, 16'h5555, 16'hAAAA, 16'h1001};
    foreach (w[i]) begin
      p.send(1'b0, w[i]);
      shown = w[i] & 16'hEFFF;
      rd(5'h05, shown);
    end
  endtask : t_base

  // Next page only lands once negotiation is complete with next pages on
  task t_next;
    @(posedge ref_clk);
    next_page_enable <= 1'b1;
    p.send(1'b1, 16'h1234);
    rd(5'h05, shown);
    @(posedge ref_clk);
    an_complete <= 1'b1;
    p.send(1'b1, 16'hF00F);
    rd(5'h05, 16'hF00F);
    chk("view", 16'h0001, {15'h0000, next_page_view});
    ack(1'b0);
    rd(5'h05, 16'hB00F);
    p.send(1'b0, 16'h1001);
    shown = 16'h0001;
    rd(5'h05, shown);
    chk("view", 16'h0000, {15'h0000, next_page_view});
    @(posedge ref_clk);
    next_page_enable <= 1'b0;
    p.send(1'b1, 16'h8421);
    rd(5'h05, shown);
  endtask : t_next

  // Acknowledge follows the negotiation logic; a page in the same cycle wins
  task t_ack;
    ack(1'b1);
    shown[14] = 1'b1;
    rd(5'h05, shown);
    ack(1'b0);
    shown[14] = 1'b0;
    rd(5'h05, shown);
    fork
      p.send(1'b0, 16'h2222);
      ack(1'b1);
    join
    shown = 16'h2222;
    rd(5'h05, shown);
  endtask : t_ack

  // Software write leaves the word alone; unmapped address reads zero
  task t_write;
    @(posedge ref_clk);
    mgmt_wr_en <= 1'b1;
    mgmt_addr <= 5'h05;
    mgmt_wr_data <= 16'hAFFF;
    @(posedge ref_clk);
    mgmt_wr_en <= 1'b0;
    rd(5'h05, shown);
    rd(5'h06, 16'h0000);
  endtask : t_write

  // Mid-run reset clears both pages and returns to the base view
  task t_rst2;
    @(posedge ref_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    arst_n <= 1'b1;
    rd(5'h05, 16'h0000);
    chk("view", 16'h0000, {15'h0000, next_page_view});
  endtask : t_rst2

  task wrap_up;
    $display("checks %0d errors %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // Main sequence
  initial begin
    arst_n = 1'b0;
    an_complete = 1'b0;
    next_page_enable = 1'b0;
    ack_update = 1'b0;
    ack_value = 1'b0;
    mgmt_rd_en = 1'b0;
    mgmt_wr_en = 1'b0;
    mgmt_addr = 5'h00;
    mgmt_wr_data = 16'h0000;
    repeat (20) @(posedge ref_clk);
    arst_n <= 1'b1;
    t_reset;
    t_base;
    t_next;
    t_ack;
    t_write;
    t_rst2;
    wrap_up;
  end

  // Hang guard, well beyond the hundred or so cycles the tests need
  initial begin
    repeat (2000) @(posedge ref_clk);
    fails++;
    wrap_up;
  end
endmodule : link_partner_ability_capture_tb_top
